// ### verilog/pec_pkg.sv
// constants and types shared by the bit error checker files
// assumes an APB master with 32-bit data and byte addresses
package pec_pkg;
   // register byte offsets
   localparam logic [7:0] PEC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] PEC_MASK_OFS   = 8'h04;
   localparam logic [7:0] PEC_MCMD_OFS   = 8'h08;
   localparam logic [7:0] PEC_FSTART_OFS = 8'h0C;
   localparam logic [7:0] PEC_FLEN_OFS   = 8'h10;
   localparam logic [7:0] PEC_FMASK_OFS  = 8'h14;
   localparam logic [7:0] PEC_DELAY_OFS  = 8'h18;
   localparam logic [7:0] PEC_CSEL_OFS   = 8'h1C;
   localparam logic [7:0] PEC_CVAL_OFS   = 8'h20;
   localparam logic [7:0] PEC_STAT_OFS   = 8'h24;
   // control field positions
   localparam int PEC_CTRL_PAT  = 0;
   localparam int PEC_CTRL_POL  = 2;
   localparam int PEC_CTRL_LEN  = 3;
   localparam int PEC_CTRL_JTOL = 6;
   localparam int PEC_CTRL_FRM  = 7;
   localparam int PEC_CTRL_REO  = 8;
   localparam int PEC_CTRL_RUN  = 9;
   localparam int PEC_CTRL_W    = 10;
   // mask command bits
   localparam int PEC_MCMD_SET = 0;
   localparam int PEC_MCMD_CLR = 1;
   localparam int PEC_MCMD_CNT = 2;
   // values after reset
   localparam logic [9:0]  PEC_CTRL_RST   = 10'h300;
   localparam logic [31:0] PEC_MASK_RST   = 32'h0000_0000;
   localparam logic [15:0] PEC_FSTART_RST = 16'h0000;
   localparam logic [15:0] PEC_FLEN_RST   = 16'h0100;
   localparam logic [31:0] PEC_FMASK_RST  = 32'h0000_0000;
   localparam logic [7:0]  PEC_DELAY_RST  = 8'h80;
   // sync loss: errors within one block of bits
   localparam logic [4:0]  PEC_BLK_LAST   = 5'h1F;
   localparam logic [5:0]  PEC_LOSS_ERRS  = 6'h08;
   localparam int          PEC_LFSR_W     = 31;
   localparam int          PEC_FIFO_DEPTH = 8;

   typedef enum logic [1:0] {
      PEC_PAT_PRBS  = 2'h0,
      PEC_PAT_ZSUB  = 2'h1,
      PEC_PAT_DATA  = 2'h2,
      PEC_PAT_MIXED = 2'h3
   } pec_pat_t;

   typedef enum logic [1:0] {
      PEC_ST_HUNT = 2'b01,
      PEC_ST_SYNC = 2'b10
   } pec_st_t;
endpackage : pec_pkg

// ### verilog/pec_fifo.sv
// small synchronous fifo with valid/ready on both ports
// assumes one clock; in_ready comes from a flop
`timescale 1ns/100ps
module pec_fifo
   import pec_pkg::*;
#(
   parameter int W     = 1,
   parameter int DEPTH = PEC_FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic                    not_full;
   } pec_fifo_state_t;

   pec_fifo_state_t s, next_s;
   logic push, pop;

   assign in_ready  = s.not_full;
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rp];

   always_comb begin
      next_s = s;
      push = in_valid & s.not_full;
      pop  = out_valid & out_ready;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = AW'(s.wp + 1'b1);
      end
      if (pop) begin
         next_s.rp = AW'(s.rp + 1'b1);
      end
      case ({push, pop})
         2'b10:   next_s.cnt = (AW+1)'(s.cnt + 1'b1);
         2'b01:   next_s.cnt = (AW+1)'(s.cnt - 1'b1);
         default: next_s.cnt = s.cnt;
      endcase
      next_s.not_full = (next_s.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.not_full <= 1'b1;
      end else begin
         s <= next_s;
      end
   end
endmodule : pec_fifo

// ### verilog/pec_checker.sv
// serial bit error checker with APB register file
// assumes DIN is synchronous to CORE_CLK, one bit per valid beat
//
// Operation
// R1: four reference types: pseudo-random, zero-substituted, user data, mixed; only pseudo-random is checked here.
// R2: reference period 2^n-1, n from 7,9,10,11,15,20,23,31.
// R3: mark ratio follows polarity: true gives 1/2, inverted gives 1/2inv.
// R4: true polarity reads high as 0, inverted reads high as 1.
// R5: 32 route error counters; route mask excludes chosen routes.
// R6: one action sets all route mask bits, another clears all.
// R7: delay stage tracks phase unless jitter-tolerant mode is on.
// R8: source keeps input unmodulated during delay calibration.
// R9: source enables jitter-tolerant mode before starting modulation.
// R10: frame start, length and mask act only in framed sync mode.
// R11: controller disables auto channel reordering behind a PAM4 decoder.
// R12: each bit compared to reference; unmasked mismatch bumps its route.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
module pec_checker
   import pec_pkg::*;
#(
   parameter int ROUTES = 32,
   parameter int CNT_W  = 16
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        DIN,
   input  wire logic        DIN_VALID,
   output logic             DIN_READY,
   input  wire logic        PHASE_EARLY,
   input  wire logic        PHASE_LATE,
   output logic [7:0]       DLY_TAP,
   output logic             DLY_TRACK,
   output logic             AUTO_REORDER,
   output logic             SYNC_OK
);
   typedef struct packed {
      logic [PEC_CTRL_W-1:0]         ctrl;
      logic [ROUTES-1:0]             route_mask;
      logic [15:0]                   frame_start;
      logic [15:0]                   frame_len;
      logic [31:0]                   frame_mask;
      logic [7:0]                    dly_tap;
      logic [4:0]                    cnt_sel;
      logic                          pready;
      logic                          pslverr;
      logic [31:0]                   prdata;
      pec_st_t                       st;
      logic [PEC_LFSR_W-1:0]         lfsr;
      logic [4:0]                    load_cnt;
      logic [4:0]                    route;
      logic [15:0]                   frame_pos;
      logic [4:0]                    blk_cnt;
      logic [5:0]                    blk_err;
      logic [ROUTES-1:0][CNT_W-1:0]  err_cnt;
      logic                          dly_track;
      logic                          reorder;
      logic                          sync_ok;
   } pec_state_t;

   // all state in one record; next_s is what the next edge loads
   pec_state_t s, next_s;
   logic       fifo_valid;
   logic       fifo_data;
   logic       run;

   // draining stops while run is low, so the fifo fills and stalls DIN
   assign run = s.ctrl[PEC_CTRL_RUN];

   pec_fifo #(
      .W     (1),
      .DEPTH (PEC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (CORE_CLK),
      .rst       (RST),
      .in_valid  (DIN_VALID),
      .in_ready  (DIN_READY),
      .in_data   (DIN),
      .out_valid (fifo_valid),
      .out_ready (run),
      .out_data  (fifo_data)
   );

   // stage count minus one and second tap for each length code
   function automatic logic [4:0] len_m1(input logic [2:0] c);
      case (c)
         3'h0:    len_m1 = 5'h06;
         3'h1:    len_m1 = 5'h08;
         3'h2:    len_m1 = 5'h09;
         3'h3:    len_m1 = 5'h0A;
         3'h4:    len_m1 = 5'h0E;
         3'h5:    len_m1 = 5'h13;
         3'h6:    len_m1 = 5'h16;
         default: len_m1 = 5'h1E;
      endcase
   endfunction : len_m1

   function automatic logic [4:0] tap_m1(input logic [2:0] c);
      case (c)
         3'h0:    tap_m1 = 5'h05;
         3'h1:    tap_m1 = 5'h04;
         3'h2:    tap_m1 = 5'h06;
         3'h3:    tap_m1 = 5'h08;
         3'h4:    tap_m1 = 5'h0D;
         3'h5:    tap_m1 = 5'h02;
         3'h6:    tap_m1 = 5'h11;
         default: tap_m1 = 5'h1B;
      endcase
   endfunction : tap_m1

   logic                  access;
   logic                  mapped;
   logic                  wr_now;
   logic [7:0]            ofs;
   logic [31:0]           rd_val;
   logic                  bit_in;
   logic                  ref_bit;
   logic                  mism;
   logic                  is_prbs;
   logic                  frm_excl;
   logic [15:0]           frm_rel;
   logic [2:0]            len_code;
   logic                  do_bit;
   logic [CNT_W-1:0]      cur_cnt;
   logic [5:0]            blk_tot;

   assign PRDATA       = s.prdata;
   assign PREADY       = s.pready;
   assign PSLVERR      = s.pslverr;
   assign DLY_TAP      = s.dly_tap;
   assign DLY_TRACK    = s.dly_track;
   assign AUTO_REORDER = s.reorder;
   assign SYNC_OK      = s.sync_ok;

   always_comb begin
      next_s   = s;
      ofs      = PADDR[7:0];
      access   = PSEL & PENABLE;
      len_code = s.ctrl[PEC_CTRL_LEN +: 3];
      is_prbs  = (s.ctrl[PEC_CTRL_PAT +: 2] == PEC_PAT_PRBS); // R1
      // only the low page decodes; anything above it is refused
      case (ofs)
         PEC_CTRL_OFS, PEC_MASK_OFS, PEC_MCMD_OFS, PEC_FSTART_OFS,
         PEC_FLEN_OFS, PEC_FMASK_OFS, PEC_DELAY_OFS, PEC_CSEL_OFS,
         PEC_CVAL_OFS, PEC_STAT_OFS: mapped = (PADDR[11:8] == 4'h0);
         default: mapped = 1'b0;
      endcase
      case (ofs)
         PEC_CTRL_OFS:   rd_val = {22'h0, s.ctrl};
         PEC_MASK_OFS:   rd_val = s.route_mask;
         PEC_FSTART_OFS: rd_val = {16'h0, s.frame_start};
         PEC_FLEN_OFS:   rd_val = {16'h0, s.frame_len};
         PEC_FMASK_OFS:  rd_val = s.frame_mask;
         PEC_DELAY_OFS:  rd_val = {24'h0, s.dly_tap};
         PEC_CSEL_OFS:   rd_val = {27'h0, s.cnt_sel};
         PEC_CVAL_OFS:   rd_val = 32'(s.err_cnt[s.cnt_sel]);
         // bit0 mark ratio 1/2inv, bit1 sync, bit2 tracking
         PEC_STAT_OFS:   rd_val = {29'h0, s.dly_track, s.sync_ok,
                                   s.ctrl[PEC_CTRL_POL]}; // R3
         default:        rd_val = 32'h0000_0000;
      endcase

      // one wait state; data and error are set with pready
      // error must not outlive the answer cycle, or a later read looks bad
      next_s.pready  = access & ~s.pready;
      next_s.pslverr = 1'b0;
      if (access & ~s.pready) begin
         next_s.prdata  = (mapped & ~PWRITE) ? rd_val : 32'h0000_0000;
         next_s.pslverr = ~mapped;
      end
      // writes land in the answer cycle, once per pready pulse; a held request writes again every second cycle
      wr_now = access & s.pready & PWRITE & mapped;

      // received bit path
      do_bit  = fifo_valid & run;
      bit_in  = fifo_data ^ ~s.ctrl[PEC_CTRL_POL]; // R4
      ref_bit = s.lfsr[len_m1(len_code)] ^ s.lfsr[tap_m1(len_code)]; // R2
      mism    = bit_in ^ ref_bit;
      frm_rel = 16'(s.frame_pos - s.frame_start);
      // frame settings are ignored unless framed sync is selected
      frm_excl = s.ctrl[PEC_CTRL_FRM] & (s.frame_pos >= s.frame_start) &
                 (frm_rel < 16'h0020) & s.frame_mask[frm_rel[4:0]]; // R10
      blk_tot = 6'(s.blk_err + {5'h0, mism & ~frm_excl});

      if (do_bit) begin
         // route steps on every drained bit, whatever the pattern type
         next_s.route = 5'(s.route + 1'b1);
         if (s.ctrl[PEC_CTRL_FRM]) begin // R10
            if (s.frame_pos >= 16'(s.frame_len - 1'b1))
               next_s.frame_pos = 16'h0000;
            else
               next_s.frame_pos = 16'(s.frame_pos + 1'b1);
         end
         if (is_prbs) begin
            case (s.st)
               PEC_ST_HUNT: begin
                  // seed the reference from n received bits
                  next_s.lfsr = {s.lfsr[PEC_LFSR_W-2:0], bit_in};
                  if (s.load_cnt == len_m1(len_code)) begin
                     next_s.st      = PEC_ST_SYNC;
                     next_s.blk_cnt = 5'h00;
                     next_s.blk_err = 6'h00;
                  end else begin
                     next_s.load_cnt = 5'(s.load_cnt + 1'b1);
                  end
               end
               PEC_ST_SYNC: begin
                  // reference runs free; a received error never feeds back
                  next_s.lfsr = {s.lfsr[PEC_LFSR_W-2:0], ref_bit}; // R2
                  // sync loss judged per block of 32 checked bits
                  next_s.blk_cnt = 5'(s.blk_cnt + 1'b1);
                  next_s.blk_err = blk_tot;
                  if (s.blk_cnt == PEC_BLK_LAST) begin
                     next_s.blk_err = 6'h00;
                     if (blk_tot >= PEC_LOSS_ERRS) begin
                        next_s.st       = PEC_ST_HUNT;
                        next_s.load_cnt = 5'h00;
                     end
                  end
               end
               default: begin
                  next_s.st       = PEC_ST_HUNT;
                  next_s.load_cnt = 5'h00;
               end
            endcase
         end
      end

      // counter clear loses to an error in the same cycle
      if (wr_now && ofs == PEC_MCMD_OFS && PWDATA[PEC_MCMD_CNT]) begin
         next_s.err_cnt = '0;
      end
      // counters saturate rather than wrap, so a long run never looks clean
      cur_cnt = s.err_cnt[s.route];
      if (do_bit && is_prbs && s.st == PEC_ST_SYNC && mism && !frm_excl
          && !s.route_mask[s.route]) begin // R5 R12
         if (wr_now && ofs == PEC_MCMD_OFS && PWDATA[PEC_MCMD_CNT])
            next_s.err_cnt[s.route] = CNT_W'(1);
         else if (cur_cnt != {CNT_W{1'b1}})
            next_s.err_cnt[s.route] = CNT_W'(cur_cnt + 1'b1);
      end

      // delay stage: closed-loop correction only when not jitter-tolerant
      if (s.dly_track) begin // R7
         if (PHASE_EARLY && !PHASE_LATE && s.dly_tap != 8'hFF)
            next_s.dly_tap = 8'(s.dly_tap + 1'b1);
         else if (PHASE_LATE && !PHASE_EARLY && s.dly_tap != 8'h00)
            next_s.dly_tap = 8'(s.dly_tap - 1'b1);
      end

      // bus writes come last so software wins over the tracking loop
      if (wr_now) begin
         case (ofs)
            PEC_CTRL_OFS: begin
               next_s.ctrl     = PWDATA[PEC_CTRL_W-1:0];
               // new pattern settings restart synchronization
               next_s.st       = PEC_ST_HUNT;
               next_s.load_cnt = 5'h00;
            end
            PEC_MASK_OFS: next_s.route_mask = PWDATA[ROUTES-1:0]; // R5
            PEC_MCMD_OFS: begin
               if (PWDATA[PEC_MCMD_SET])
                  next_s.route_mask = {ROUTES{1'b1}}; // R6
               else if (PWDATA[PEC_MCMD_CLR])
                  next_s.route_mask = {ROUTES{1'b0}}; // R6
            end
            PEC_FSTART_OFS: next_s.frame_start = PWDATA[15:0];
            PEC_FLEN_OFS:   next_s.frame_len   = PWDATA[15:0];
            PEC_FMASK_OFS:  next_s.frame_mask  = PWDATA;
            PEC_DELAY_OFS:  next_s.dly_tap     = PWDATA[7:0];
            PEC_CSEL_OFS:   next_s.cnt_sel     = PWDATA[4:0];
            default: ;
         endcase
      end

      next_s.dly_track = ~next_s.ctrl[PEC_CTRL_JTOL]; // R7
      next_s.reorder   = next_s.ctrl[PEC_CTRL_REO];
      // sync flag lags the state by one cycle; tracking and reorder flags load with ctrl
      next_s.sync_ok   = is_prbs & (s.st == PEC_ST_SYNC);
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      // outputs come up at their idle levels, no answer pending
      if (RST) begin
         s             <= '0;
         s.ctrl        <= PEC_CTRL_RST;
         s.route_mask  <= PEC_MASK_RST;
         s.frame_start <= PEC_FSTART_RST;
         s.frame_len   <= PEC_FLEN_RST;
         s.frame_mask  <= PEC_FMASK_RST;
         s.dly_tap     <= PEC_DELAY_RST;
         s.st          <= PEC_ST_HUNT;
         s.dly_track   <= 1'b1;
         s.reorder     <= 1'b1;
      end else begin
         s <= next_s;
      end
   end
endmodule : pec_checker

// ### test/pec_chk_checker.sv
// checker: bus answer timing and delay-stage rules at the top ports
// assumes it is bound to pec_checker, one clock domain
`timescale 1ns/100ps
module pec_chk
   import pec_pkg::*;
#(
   parameter int ROUTES = 32,
   parameter int CNT_W  = 16
) (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        DIN,
   input wire logic        DIN_VALID,
   input wire logic        DIN_READY,
   input wire logic        PHASE_EARLY,
   input wire logic        PHASE_LATE,
   input wire logic [7:0]  DLY_TAP,
   input wire logic        DLY_TRACK,
   input wire logic        AUTO_REORDER,
   input wire logic        SYNC_OK
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   logic acc;
   logic ctlw;
   logic apbw;
   assign acc  = PSEL && PENABLE && !PREADY;
   assign apbw = PSEL && PWRITE;
   assign ctlw = acc && PWRITE && PADDR == {4'h0, PEC_CTRL_OFS};

   rdy_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held past one cycle");
   rdy_answer_a: assert property (acc |=> PREADY)
      else $error("access not answered next cycle");
   rdy_cause_a: assert property (PREADY |-> $past(acc))
      else $error("ready without an access");
   err_quiet_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error answer malformed");
   unmapped_err_a: assert property (acc && (PADDR[11:8] != 4'h0 ||
      PADDR[7:0] > PEC_STAT_OFS) |=> PSLVERR)
      else $error("unmapped access not refused");
   reorder_follow_a: assert property (ctlw |-> ##3
      AUTO_REORDER == $past(PWDATA[PEC_CTRL_REO], 3))
      else $error("reorder output does not follow control");
   track_follow_a: assert property (ctlw |-> ##3
      DLY_TRACK != $past(PWDATA[PEC_CTRL_JTOL], 3))
      else $error("tracking output does not follow control");
   tap_up_a: assert property (DLY_TRACK && PHASE_EARLY && !PHASE_LATE
      && !apbw && DLY_TAP != 8'hFF |=> DLY_TAP == $past(DLY_TAP) + 8'h01)
      else $error("tap did not step up");
   tap_frozen_a: assert property (!DLY_TRACK && !apbw |=> $stable(DLY_TAP))
      else $error("tap moved with correction off");
endmodule : pec_chk

bind pec_checker pec_chk #(.ROUTES(ROUTES), .CNT_W(CNT_W)) u_chk (
   .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .DIN(DIN), .DIN_VALID(DIN_VALID),
   .DIN_READY(DIN_READY), .PHASE_EARLY(PHASE_EARLY),
   .PHASE_LATE(PHASE_LATE), .DLY_TAP(DLY_TAP), .DLY_TRACK(DLY_TRACK),
   .AUTO_REORDER(AUTO_REORDER), .SYNC_OK(SYNC_OK));

// ### test/pec_src.sv
// partner: far-side source sending a serial prbs pattern, valid/ready
// assumes the bench sets polarity and length to match the checker
`timescale 1ns/100ps
module pec_src (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic en,
   input  wire logic pol,
   input  wire logic len9,
   input  wire logic flip,
   input  wire logic ready,
   output logic      dout,
   output logic      valid
);
   logic [8:0] s;
   logic       nb;
   logic       last;
   assign nb    = len9 ? s[8] ^ s[4] : s[6] ^ s[5];
   assign valid = en;
   // idle line shows the inverse of the last bit, never a stale copy
   assign dout  = en ? (nb ^ flip ^ !pol) : !last;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s    <= 9'h1FF;
         last <= 1'b0;
      end else if (en && ready) begin
         s    <= {s[7:0], nb};
         last <= dout;
      end
   end
endmodule : pec_src

// ### test/test_prbs_error_checker_config.sv
// bench for the bit error checker: bus tasks, pattern source, checks
// assumes pec_checker with pec_chk bound, pec_src as the far side
`timescale 1ns/100ps
module test_prbs_error_checker_config
   import pec_pkg::*;
;
   logic        CORE_CLK = 1'b0;
   logic        RST = 1'b1;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic        PHASE_EARLY = 1'b0;
   logic        PHASE_LATE = 1'b0;
   logic        en = 1'b0;
   logic        pol = 1'b0;
   logic        len9 = 1'b0;
   logic        flip = 1'b0;
   logic [31:0] PRDATA, q, sum;
   logic [7:0]  DLY_TAP;
   logic        PREADY, PSLVERR, DIN, DIN_VALID, DIN_READY, e;
   logic        DLY_TRACK, AUTO_REORDER, SYNC_OK;
   int          num_errors = 0;
   int          n_compared = 0;
   int          i;
   int          nz = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;

   pec_checker u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DIN(DIN),
      .DIN_VALID(DIN_VALID), .DIN_READY(DIN_READY),
      .PHASE_EARLY(PHASE_EARLY), .PHASE_LATE(PHASE_LATE), .DLY_TAP(DLY_TAP),
      .DLY_TRACK(DLY_TRACK), .AUTO_REORDER(AUTO_REORDER), .SYNC_OK(SYNC_OK));
   pec_src u_src (.clk(CORE_CLK), .rst(RST), .en(en), .pol(pol), .len9(len9),
      .flip(flip), .ready(DIN_READY), .dout(DIN), .valid(DIN_VALID));

   task automatic print_verdict();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask : chk

   // one transfer; q and e carry the answer
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {4'h0, a};
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(32'h0, 32'h1);
         print_verdict();
      end
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task automatic wait_sync();
      // a stale sync flag stands one cycle past a restart
      repeat (2) @(posedge CORE_CLK);
      for (i = 0; i < 400 && SYNC_OK !== 1'b1; i++) @(posedge CORE_CLK);
      chk(SYNC_OK, 1'b1);
      if (SYNC_OK !== 1'b1) print_verdict();
   endtask : wait_sync

   task automatic cnt_sum();
      sum = 32'h0;
      for (i = 0; i < 32; i++) begin
         apb(1'b1, PEC_CSEL_OFS, 32'(i));
         apb(1'b0, PEC_CVAL_OFS, 32'h0);
         sum = sum + q;
      end
   endtask : cnt_sum

   // flips one accepted bit, then lets it reach the counters
   task automatic inject();
      @(posedge CORE_CLK);
      flip <= 1'b1;
      @(posedge CORE_CLK);
      flip <= 1'b0;
      repeat (12) @(posedge CORE_CLK);
   endtask : inject

   task automatic phase(input logic up, input logic [7:0] exp);
      PHASE_EARLY <= up;
      PHASE_LATE <= !up;
      repeat (5) @(posedge CORE_CLK);
      PHASE_EARLY <= 1'b0;
      PHASE_LATE <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      chk(DLY_TAP, exp);
   endtask : phase

   initial begin
      repeat (3) @(posedge CORE_CLK);
      RST <= 1'b0;
      apb(1'b0, PEC_CTRL_OFS, 32'h0); chk(q, 32'h300);
      apb(1'b0, PEC_MASK_OFS, 32'h0); chk(q, 32'h0);
      apb(1'b0, PEC_FLEN_OFS, 32'h0); chk(q, 32'h100);
      apb(1'b0, PEC_DELAY_OFS, 32'h0); chk(q, 32'h80);
      apb(1'b0, 8'h28, 32'h0);
      chk(e, 1'b1);
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, PEC_CTRL_OFS, 32'h100 | p);
         apb(1'b0, PEC_CTRL_OFS, 32'h0); chk(q, 32'h100 | p);
      end
      apb(1'b1, PEC_CTRL_OFS, 32'h140);
      repeat (3) @(posedge CORE_CLK);
      chk(DLY_TRACK, 1'b0);
      phase(1'b1, 8'h80);
      apb(1'b1, PEC_CTRL_OFS, 32'h100);
      repeat (3) @(posedge CORE_CLK);
      phase(1'b0, 8'h7B);
      apb(1'b1, PEC_DELAY_OFS, 32'hFE);
      phase(1'b1, 8'hFF);
      en <= 1'b1;
      apb(1'b1, PEC_CTRL_OFS, 32'h000);
      repeat (20) @(posedge CORE_CLK);
      chk(DIN_READY, 1'b0);
      chk(AUTO_REORDER, 1'b0);
      apb(1'b1, PEC_CTRL_OFS, 32'h300);
      wait_sync();
      apb(1'b0, PEC_STAT_OFS, 32'h0); chk(q[2:0], 3'b110);
      apb(1'b1, PEC_MCMD_OFS, 32'h4);
      inject();
      cnt_sum(); chk(sum, 32'h1);
      apb(1'b1, PEC_MCMD_OFS, 32'h1);
      apb(1'b0, PEC_MASK_OFS, 32'h0); chk(q, 32'hFFFFFFFF);
      inject();
      cnt_sum(); chk(sum, 32'h1);
      apb(1'b1, PEC_MCMD_OFS, 32'h2);
      apb(1'b0, PEC_MASK_OFS, 32'h0); chk(q, 32'h0);
      // drain old bits first so the new seed holds only the new pattern
      en <= 1'b0;
      repeat (12) @(posedge CORE_CLK);
      pol <= 1'b1;
      len9 <= 1'b1;
      en <= 1'b1;
      apb(1'b1, PEC_CTRL_OFS, 32'h30C);
      wait_sync();
      apb(1'b0, PEC_STAT_OFS, 32'h0); chk(q[2:0], 3'b111);
      apb(1'b1, PEC_MCMD_OFS, 32'h4);
      inject();
      cnt_sum(); chk(sum, 32'h1);
      // frame mask set but framing off: errors still count
      apb(1'b1, PEC_FMASK_OFS, 32'hFFFFFFFF);
      apb(1'b1, PEC_FLEN_OFS, 32'h20);
      apb(1'b1, PEC_MCMD_OFS, 32'h4);
      inject();
      cnt_sum(); chk(sum, 32'h1);
      apb(1'b1, PEC_CTRL_OFS, 32'h38C);
      wait_sync();
      apb(1'b1, PEC_MCMD_OFS, 32'h4);
      inject();
      cnt_sum(); chk(sum, 32'h0);
      // wrong polarity: every seed fails, hunt 9 bits, lose sync after 32
      pol <= 1'b0;
      apb(1'b1, PEC_CTRL_OFS, 32'h30C);
      repeat (300) @(posedge CORE_CLK);
      for (i = 0; i < 41; i++) begin
         @(posedge CORE_CLK);
         if (SYNC_OK === 1'b0) begin
            nz++;
         end
      end
      chk(nz, 32'h9);
      print_verdict();
   end
endmodule : test_prbs_error_checker_config
